// >>> rtl/supply_seq_pkg.sv
// Constants, types and reset values of the supply start-up and fault sequencer
package supply_seq_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int INIT_TIME_MS = 2;
   localparam int SW_FREQ_KHZ = 571;
   localparam logic [7:0] INIT_MS = 8'(INIT_TIME_MS);
   // Word offsets of the register file
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_VOUT = 6'h01;
   localparam logic [5:0] A_SSDLY = 6'h02;
   localparam logic [5:0] A_SSRAMP = 6'h03;
   localparam logic [5:0] A_PGDLY = 6'h04;
   localparam logic [5:0] A_PGTOL = 6'h05;
   localparam logic [5:0] A_OVPCT = 6'h06;
   localparam logic [5:0] A_INPUT_LOW_LOCKOUT = 6'h07;
   localparam logic [5:0] A_UVRESP = 6'h08;
   localparam logic [5:0] A_OVRESP = 6'h09;
   localparam logic [5:0] A_STATUS = 6'h0a;
   localparam logic [5:0] A_CEIL = 6'h0b;
   // Limits in mV, ms and percent, reset values and response codes
   localparam logic [11:0] VOUT_MIN_MV = 12'h258;
   localparam logic [12:0] OUTPUT_VOLTAGE_CEILING_MV = 13'he10;
   localparam logic [15:0] INPUT_LOW_LOCKOUT_MIN_MV = 16'h0b22;
   localparam logic [15:0] INPUT_LOW_LOCKOUT_MAX_MV = 16'h3e80;
   localparam logic [7:0] PGDLY_MAX_MS = 8'hc8;
   localparam logic [6:0] PG_TOL_RST = 7'h0a;
   localparam logic [6:0] OV_PCT_RST = 7'h0f;
   localparam logic [6:0] GAIN_RST = 7'h32;
   localparam logic [3:0] RETRY_FOREVER = 4'hf;
   localparam logic [1:0] UV_CONTINUE = 2'h0;
   localparam logic [1:0] UV_DELAY_OFF = 2'h1;
   localparam logic [1:0] UV_SHUTDOWN = 2'h2;
   // Strap table, index 0 is the smallest select resistor
   localparam logic [11:0] VSEL_MV [29] = '{
      12'h258, 12'h28a, 12'h2bc, 12'h2ee, 12'h320, 12'h352, 12'h384, 12'h3b6,
      12'h3e8, 12'h41a, 12'h44c, 12'h47e, 12'h4b0, 12'h4e2, 12'h514, 12'h578,
      12'h5dc, 12'h640, 12'h6a4, 12'h708, 12'h76c, 12'h7d0, 12'h834, 12'h898,
      12'h8fc, 12'h9c4, 12'haf0, 12'hbb8, 12'hce4};
   typedef enum logic [6:0] {
      ST_OFF = 7'h01, ST_PRE = 7'h02, ST_RAMP = 7'h04, ST_COMP = 7'h08,
      ST_PGW = 7'h10, ST_ON = 7'h20, ST_FAULT = 7'h40
   } seq_state_t;
   typedef struct packed {
      logic cyc; logic stb; logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic ack; logic [31:0] dat;
   } wb_rsp_t;
   typedef struct packed {
      logic hs; logic ls; logic [11:0] ref_mv; logic ac_start; logic [6:0] gain;
      logic sync_out; logic ext_sel;
   } drive_t;
   typedef struct packed {
      seq_state_t st; logic strap_ok; logic [11:0] vsel; logic [11:0] vout_cmd;
      logic bus_on; logic de_en; logic sync_out; logic pg_low; logic ac_en;
      logic [6:0] gain; logic [7:0] ss_dly; logic [7:0] ss_ramp; logic [7:0] pg_dly;
      logic pg_dly_set; logic [6:0] pg_tol; logic [6:0] ov_pct; logic [15:0] input_low_lockout_mv;
      logic [1:0] uv_mode; logic [3:0] uv_retry; logic [7:0] uv_dly; logic ov_mode;
      logic [3:0] ov_retry; logic [17:0] tick_cnt; logic [7:0] ms_cnt; logic [7:0] uv_ms;
      logic [11:0] ref_mv; logic [11:0] start_mv; logic down; logic pg; logic pg_out;
      logic ov_flag; logic uv_flag; logic latched; logic lsh; logic [3:0] used;
      logic hs; logic ls; logic ac_start; logic ack; logic [31:0] rdata;
      logic en_s1; logic en_s2; logic xc_s1; logic xc_s2;
   } seq_regs_t;
   localparam seq_regs_t SEQ_RST = '{st: ST_OFF, ac_en: 1'b1, gain: GAIN_RST,
      pg_tol: PG_TOL_RST, ov_pct: OV_PCT_RST, input_low_lockout_mv: INPUT_LOW_LOCKOUT_MIN_MV,
      uv_mode: UV_SHUTDOWN, uv_retry: RETRY_FOREVER, ov_retry: RETRY_FOREVER,
      vout_cmd: VOUT_MIN_MV, vsel: VOUT_MIN_MV, default: '0};
endpackage

// >>> rtl/supply_startup_fault_sequencer.sv
// Start-up sequencer, output-good and fault responses of a step-down supply
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module supply_startup_fault_sequencer #(
   parameter int MS_TICK_CYCLES = supply_seq_pkg::MS_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire supply_seq_pkg::wb_req_t wb_i,
   output supply_seq_pkg::wb_rsp_t wb_o,
   input wire logic turn_on_i,
   input wire logic ext_sync_i,
   input wire logic [4:0] voltage_select_resistor_i,
   input wire logic [11:0] output_sense_positive_i,
   input wire logic [15:0] vin_mv_i,
   input wire logic single_phase_i,
   input wire logic light_load_i,
   input wire logic ac_done_i,
   output supply_seq_pkg::drive_t drv_o,
   output logic output_good_flag_o,
   output logic [6:0] state_o
);
   import supply_seq_pkg::*;

   localparam logic [17:0] TICK_LAST = 18'(MS_TICK_CYCLES - 1);
   localparam logic [6:0] RUN_MASK = ST_RAMP | ST_COMP | ST_PGW | ST_ON;

   seq_regs_t s;
   seq_regs_t n;
   logic ms_tick;
   logic enable;
   logic ov_now;
   logic uv_low;
   logic win_ok;
   logic diode_em;
   logic ext_clk;
   logic wr_req;
   logic [12:0] ceil_mv;
   logic [12:0] ceil_lim;
   logic [13:0] ov_lim;
   logic [11:0] tol_mv;
   logic [11:0] diff_mv;
   logic [11:0] lut_mv;
   logic [11:0] ramp_mv;
   logic [19:0] ramp_prod;
   logic [7:0] pre_ms;
   logic [7:0] pg_eff;
   logic [31:0] rd_val;
   logic [31:0] wmask;
   logic [31:0] wv;
   logic [12:0] v13;

   // Shared arithmetic on the registered state
   assign ms_tick = (s.tick_cnt == TICK_LAST);
   assign enable = s.en_s2 | s.bus_on;
   assign ext_clk = s.xc_s2;
   assign lut_mv = (voltage_select_resistor_i > 5'd28) ? VSEL_MV[28]
      : VSEL_MV[voltage_select_resistor_i];
   assign ceil_mv = {1'b0, s.vsel} + 13'(s.vsel / 12'd10);
   assign ceil_lim = (ceil_mv > OUTPUT_VOLTAGE_CEILING_MV) ? OUTPUT_VOLTAGE_CEILING_MV : ceil_mv;
   assign ov_lim = 14'((20'(s.vout_cmd) * (20'd100 + 20'(s.ov_pct))) / 20'd100);
   assign ov_now = {2'b00, output_sense_positive_i} > ov_lim;
   assign uv_low = vin_mv_i < s.input_low_lockout_mv;
   assign tol_mv = 12'((19'(s.ref_mv) * 19'(s.pg_tol)) / 19'd100);
   assign diff_mv = (output_sense_positive_i > s.ref_mv) ? output_sense_positive_i - s.ref_mv
      : s.ref_mv - output_sense_positive_i;
   assign win_ok = diff_mv <= tol_mv;
   // Pre-bias start: fraction of the remaining rise, so total time matches
   assign ramp_prod = 20'(s.vout_cmd - s.start_mv) * 20'(s.ms_cnt);
   assign ramp_mv = (s.ss_ramp == 8'h00) ? s.vout_cmd
      : s.start_mv + 12'(ramp_prod / 20'(s.ss_ramp));
   assign pre_ms = (s.ss_dly > INIT_MS) ? s.ss_dly : INIT_MS;
   assign pg_eff = s.pg_dly_set ? s.pg_dly : s.ss_ramp;
   assign diode_em = s.de_en & single_phase_i & light_load_i;
   assign wr_req = wb_i.cyc & wb_i.stb & ~s.ack;

   // Read mux, also the base for byte-lane merges on writes
   always_comb begin
      rd_val = 32'h0000_0000;
      case (wb_i.adr[7:2])
         A_CTRL: rd_val = {17'h0, s.gain, 3'h0, s.ac_en, s.pg_low, s.sync_out, s.de_en, s.bus_on};
         A_VOUT: rd_val = {20'h0, s.vout_cmd};
         A_SSDLY: rd_val = {24'h0, s.ss_dly};
         A_SSRAMP: rd_val = {24'h0, s.ss_ramp};
         A_PGDLY: rd_val = {23'h0, s.pg_dly_set, pg_eff};
         A_PGTOL: rd_val = {25'h0, s.pg_tol};
         A_OVPCT: rd_val = {25'h0, s.ov_pct};
         A_INPUT_LOW_LOCKOUT: rd_val = {16'h0, s.input_low_lockout_mv};
         A_UVRESP: rd_val = {16'h0, s.uv_dly, 2'h0, s.uv_retry, s.uv_mode};
         A_OVRESP: rd_val = {27'h0, s.ov_retry, s.ov_mode};
         A_STATUS: rd_val = {21'h0, s.st, s.pg, s.ov_flag, s.uv_flag, s.latched};
         A_CEIL: rd_val = {19'h0, ceil_lim};
         default: rd_val = 32'h0000_0000;
      endcase
      wmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
      wv = (rd_val & ~wmask) | (wb_i.dat & wmask);
      v13 = {1'b0, wv[11:0]};
   end

   // Next state: bus writes first, then sequencing, so hardware sets win
   always_comb begin
      n = s;
      n.ack = 1'b0;
      n.ac_start = 1'b0;
      n.en_s1 = turn_on_i;
      n.en_s2 = s.en_s1;
      n.xc_s1 = ext_sync_i;
      n.xc_s2 = s.xc_s1;
      n.tick_cnt = ms_tick ? 18'h0 : s.tick_cnt + 18'h1;
      if (!s.strap_ok) begin
         n.vsel = lut_mv;
         n.vout_cmd = lut_mv;
         n.strap_ok = 1'b1;
      end
      if (wr_req) begin
         n.ack = 1'b1;
         n.rdata = rd_val;
         if (wb_i.we) begin
            case (wb_i.adr[7:2])
               A_CTRL: begin
                  {n.ac_en, n.pg_low, n.sync_out, n.de_en, n.bus_on} = wv[4:0];
                  n.gain = wv[14:8];
                  if (wv[5]) begin
                     n.latched = 1'b0;
                  end
               end
               A_VOUT: begin
                  if (v13 > ceil_lim) begin
                     n.vout_cmd = ceil_lim[11:0];
                  end else if (wv[11:0] < VOUT_MIN_MV) begin
                     n.vout_cmd = VOUT_MIN_MV;
                  end else begin
                     n.vout_cmd = wv[11:0];
                  end
               end
               A_SSDLY: n.ss_dly = wv[7:0];
               A_SSRAMP: n.ss_ramp = wv[7:0];
               A_PGDLY: begin
                  n.pg_dly = (wv[7:0] > PGDLY_MAX_MS) ? PGDLY_MAX_MS : wv[7:0];
                  n.pg_dly_set = 1'b1;
               end
               A_PGTOL: n.pg_tol = wv[6:0];
               A_OVPCT: n.ov_pct = wv[6:0];
               A_INPUT_LOW_LOCKOUT: begin
                  if (wv[15:0] < INPUT_LOW_LOCKOUT_MIN_MV) begin
                     n.input_low_lockout_mv = INPUT_LOW_LOCKOUT_MIN_MV;
                  end else if (wv[15:0] > INPUT_LOW_LOCKOUT_MAX_MV) begin
                     n.input_low_lockout_mv = INPUT_LOW_LOCKOUT_MAX_MV;
                  end else begin
                     n.input_low_lockout_mv = wv[15:0];
                  end
               end
               A_UVRESP: begin
                  {n.uv_dly, n.uv_retry, n.uv_mode} = {wv[15:8], wv[5:0]};
               end
               A_OVRESP: {n.ov_retry, n.ov_mode} = wv[4:0];
               default: n.ack = 1'b1;
            endcase
         end
      end
      // Sequencer; faults are judged on the settings live this cycle
      case (s.st)
         ST_OFF: begin
            n.ms_cnt = 8'h00;
            n.used = 4'h0;
            if (enable && !uv_low) begin
               n.st = ST_PRE;
            end
         end
         ST_PRE: begin
            // Delay never shorter than initialisation
            if (uv_low) begin
               n.ms_cnt = 8'h00;
            end else if (s.ms_cnt >= pre_ms) begin
               n.ms_cnt = 8'h00;
               n.start_mv = output_sense_positive_i;
               n.ref_mv = output_sense_positive_i;
               n.down = output_sense_positive_i > s.vout_cmd;
               if (ov_now) begin
                  n.st = ST_FAULT;
                  n.ov_flag = 1'b1;
                  n.lsh = s.ov_mode & ~ext_clk;
               end else begin
                  n.st = ST_RAMP;
               end
            end else if (ms_tick) begin
               n.ms_cnt = s.ms_cnt + 8'h01;
            end
         end
         ST_RAMP: begin
            if (!s.down) begin
               n.ref_mv = ramp_mv;
            end
            if (ms_tick) begin
               n.ms_cnt = s.ms_cnt + 8'h01;
            end
            if (s.ms_cnt >= s.ss_ramp) begin
               n.ms_cnt = 8'h00;
               if (s.down) begin
                  n.st = ST_ON;
               end else begin
                  n.ref_mv = s.vout_cmd;
                  n.st = s.ac_en ? ST_COMP : ST_PGW;
                  n.ac_start = s.ac_en;
               end
            end
         end
         ST_COMP: begin
            if (ac_done_i) begin
               n.st = ST_ON;
            end
         end
         ST_PGW: begin
            if (!win_ok) begin
               n.ms_cnt = 8'h00;
            end else if (s.ms_cnt >= pg_eff) begin
               n.st = ST_ON;
            end else if (ms_tick) begin
               n.ms_cnt = s.ms_cnt + 8'h01;
            end
         end
         ST_ON: begin
            n.used = 4'h0;
            // Slew toward a new or post-pre-bias target one mV per cycle
            if (s.ref_mv < s.vout_cmd) begin
               n.ref_mv = s.ref_mv + 12'h001;
            end else if (s.ref_mv > s.vout_cmd) begin
               n.ref_mv = s.ref_mv - 12'h001;
            end
         end
         ST_FAULT: begin
            if (!uv_low && !ov_now && !s.latched) begin
               if ((s.ov_flag ? s.ov_retry : s.uv_retry) == RETRY_FOREVER) begin
                  n.st = ST_PRE;
               end else if (s.used < (s.ov_flag ? s.ov_retry : s.uv_retry)) begin
                  n.used = s.used + 4'h1;
                  n.st = ST_PRE;
               end else begin
                  n.latched = 1'b1;
               end
               if (n.st == ST_PRE) begin
                  {n.ov_flag, n.uv_flag, n.lsh, n.ms_cnt} = {3'b000, 8'h00};
               end
            end
         end
         default: n.st = ST_OFF;
      endcase
      // Running faults override the sequence above
      if ((s.st & RUN_MASK) != 7'h00) begin
         if (ov_now) begin
            n.st = ST_FAULT;
            n.ov_flag = 1'b1;
            n.lsh = s.ov_mode & ~ext_clk;
         end else if (uv_low) begin
            if (s.uv_mode == UV_SHUTDOWN) begin
               n.st = ST_FAULT;
               n.uv_flag = 1'b1;
            end else if (s.uv_mode == UV_DELAY_OFF) begin
               if (s.uv_ms >= s.uv_dly) begin
                  n.st = ST_FAULT;
                  n.uv_flag = 1'b1;
                  n.latched = 1'b1;
               end else if (ms_tick) begin
                  n.uv_ms = s.uv_ms + 8'h01;
               end
            end
         end else begin
            n.uv_ms = 8'h00;
         end
      end else begin
         n.uv_ms = 8'h00;
      end
      if (!enable) begin
         n.st = ST_OFF;
         n.latched = 1'b0;
         n.lsh = 1'b0;
      end
      n.pg = (n.st == ST_ON) && win_ok && !ov_now;
      n.pg_out = n.pg ^ n.pg_low;
      n.hs = (n.st & RUN_MASK) != 7'h00;
      n.ls = (n.hs & ~diode_em) | ((n.st == ST_FAULT) & n.lsh);
   end

   // Single state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= SEQ_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs are straight from flops, except drive sync_out, which is gated by ext_clk
   assign wb_o = '{ack: s.ack, dat: s.rdata};
   assign drv_o = '{hs: s.hs, ls: s.ls, ref_mv: s.ref_mv, ac_start: s.ac_start,
      gain: s.gain, sync_out: s.sync_out & ~ext_clk, ext_sel: ext_clk};
   assign output_good_flag_o = s.pg_out;
   assign state_o = s.st;

   chk_vout_ceiling: assert property (@(posedge clk_i) disable iff (rst_i)
      s.strap_ok |-> {1'b0, s.vout_cmd} <= ceil_lim)
      else $error("setpoint above ceiling");
   chk_vout_floor: assert property (@(posedge clk_i) disable iff (rst_i)
      s.vout_cmd >= VOUT_MIN_MV)
      else $error("setpoint below floor");
   chk_delay_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.st == ST_PRE) && $past(s.st == ST_PRE) |-> !s.hs && !s.ls)
      else $error("drivers on during delay");
   chk_pg_window: assert property (@(posedge clk_i) disable iff (rst_i)
      s.pg |-> $past(win_ok) && $past(!ov_now))
      else $error("good outside window");
   chk_ov_drops_pg: assert property (@(posedge clk_i) disable iff (rst_i)
      ov_now && (s.st == ST_ON) |=> !s.pg ##1 !output_good_flag_o ^ s.pg_low)
      else $error("good kept on overvoltage");
   chk_uv_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.st == ST_OFF) && uv_low |=> s.st != ST_PRE)
      else $error("start under lockout");
   chk_ext_clk_ov: assert property (@(posedge clk_i) disable iff (rst_i)
      ext_clk && ov_now && ((s.st & RUN_MASK) != 7'h00) && enable |=> !s.lsh)
      else $error("low-side hold with external clock");
   chk_prebias_ov: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.st == ST_PRE) && !uv_low && (s.ms_cnt >= pre_ms) && ov_now && enable
      |=> (s.st == ST_FAULT) && s.ov_flag ##1 !s.hs)
      else $error("turn-on over overvoltage limit");
   chk_comp_pg: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.st == ST_COMP) && ac_done_i && enable && !ov_now && !uv_low |=> s.st == ST_ON)
      else $error("no good after compensation");
   chk_diode_ls: assert property (@(posedge clk_i) disable iff (rst_i)
      (n.st == ST_ON) && diode_em |=> s.hs && !s.ls)
      else $error("low side on in diode emulation");
endmodule
`default_nettype wire

// >>> verification/load_model.sv
// Behavioural powered load and power train facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module load_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire supply_seq_pkg::drive_t drv_i,
   input wire logic [11:0] bias_mv_i,
   input wire logic ov_force_i,
   output logic [11:0] sense_mv_o,
   output logic ac_done_o
);
   import supply_seq_pkg::*;
   logic [2:0] ac_cnt_ff;
   // Ideal loop while switching, else the external pre-bias; ov adds a surge
   always_comb begin
      sense_mv_o = ((drv_i.hs || drv_i.ls) ? drv_i.ref_mv : bias_mv_i)
         + (ov_force_i ? 12'h190 : 12'h000);
   end
   // Compensation answer comes a few cycles late, never at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ac_cnt_ff <= 3'h0;
      end else if (drv_i.ac_start) begin
         ac_cnt_ff <= 3'h4;
      end else if (ac_cnt_ff != 3'h0) begin
         ac_cnt_ff <= ac_cnt_ff - 3'h1;
      end
   end
   always_comb ac_done_o = (ac_cnt_ff == 3'h1);
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench of the supply start-up and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import supply_seq_pkg::*;
   typedef struct packed {logic we; logic [5:0] w; logic [31:0] d; logic [31:0] e;} row_t;
   localparam int LIMIT = 20000;
   localparam row_t ROWS [20] = '{
      '{1'b0, A_CTRL, 32'h0, 32'h3210}, '{1'b0, A_PGTOL, 32'h0, 32'h0a},
      '{1'b0, A_OVPCT, 32'h0, 32'h0f}, '{1'b0, A_INPUT_LOW_LOCKOUT, 32'h0, 32'hb22},
      '{1'b0, A_UVRESP, 32'h0, 32'h3e}, '{1'b0, A_OVRESP, 32'h0, 32'h1e},
      '{1'b0, A_VOUT, 32'h0, 32'h4b0}, '{1'b0, A_CEIL, 32'h0, 32'h528},
      '{1'b1, A_VOUT, 32'hfff, 32'h528}, '{1'b1, A_VOUT, 32'h100, 32'h258},
      '{1'b1, A_INPUT_LOW_LOCKOUT, 32'h100, 32'hb22}, '{1'b1, A_INPUT_LOW_LOCKOUT, 32'hffff, 32'h3e80},
      '{1'b1, A_SSRAMP, 32'h2, 32'h2}, '{1'b0, A_PGDLY, 32'h0, 32'h2},
      '{1'b1, A_PGDLY, 32'hff, 32'h1c8}, '{1'b1, A_INPUT_LOW_LOCKOUT, 32'hb22, 32'hb22},
      '{1'b1, A_VOUT, 32'h4b0, 32'h4b0}, '{1'b1, A_SSDLY, 32'h1, 32'h1},
      '{1'b1, 6'h30, 32'h5, 32'h0}, '{1'b1, A_STATUS, 32'hffff, 32'h10}};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wb_req_t wb_req = '0;
   wb_rsp_t wb_rsp;
   logic turn_on = 1'b0;
   logic light = 1'b0;
   logic [15:0] vin_mv = 16'h2ee0;
   logic [11:0] bias_mv = 12'h000;
   logic ov_force = 1'b0;
   logic ext_sync = 1'b0;
   logic [11:0] sense_mv;
   logic ac_done;
   drive_t drv;
   logic good;
   logic [6:0] state;
   logic [31:0] rd;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   always #2.5 clk_i = ~clk_i;
   // Short ms tick keeps the soft-start counts small
   supply_startup_fault_sequencer #(.MS_TICK_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_i(wb_req), .wb_o(wb_rsp), .turn_on_i(turn_on), .ext_sync_i(ext_sync),
      .voltage_select_resistor_i(5'h0c), .output_sense_positive_i(sense_mv), .vin_mv_i(vin_mv),
      .single_phase_i(1'b1), .light_load_i(light), .ac_done_i(ac_done), .drv_o(drv),
      .output_good_flag_o(good), .state_o(state));
   load_model load (.clk_i(clk_i), .rst_i(rst_i), .drv_i(drv), .bias_mv_i(bias_mv),
      .ov_force_i(ov_force), .sense_mv_o(sense_mv), .ac_done_o(ac_done));
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold until ack is sampled at a rising edge, take data and release there
   task automatic wb_xfer(input logic we, input logic [5:0] w, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {w, 2'b00}, sel: 4'hf, dat: d};
      @(posedge clk_i);
      while (wb_rsp.ack !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      q = wb_rsp.dat;
      if (n == 50) n_mismatch++;
      wb_req <= '0;
   endtask
   // Bounded wait for a sequencer state
   task automatic wait_state(input logic [6:0] s);
      int n;
      n = 0;
      while (state !== s && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      check({25'h0, state}, {25'h0, s});
   endtask
   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      // Reset values, clamps, read-only and unmapped places
      foreach (ROWS[i]) begin
         if (ROWS[i].we) wb_xfer(1'b1, ROWS[i].w, ROWS[i].d, rd);
         wb_xfer(1'b0, ROWS[i].w, 32'h0, rd);
         check(rd, ROWS[i].e);
      end
      $display("register table test done");
      // Ramp time of 2 ms stays above the inrush advice
      @(posedge clk_i);
      turn_on <= 1'b1;
      wait_state(ST_PRE);
      check({31'h0, drv.hs}, 32'h0);
      wait_state(ST_RAMP);
      wait_state(ST_ON);
      repeat (3) @(negedge clk_i);
      check({31'h0, good}, 32'h1);
      check({25'h0, drv.gain}, 32'h32);
      wb_xfer(1'b1, A_CTRL, 32'h3218, rd);
      repeat (3) @(negedge clk_i);
      check({31'h0, good}, 32'h0);
      wb_xfer(1'b1, A_CTRL, 32'h3212, rd);
      light <= 1'b1;
      repeat (3) @(negedge clk_i);
      check({30'h0, good, drv.ls}, 32'h2);
      @(posedge clk_i);
      light <= 1'b0;
      $display("start-up test done");
      // Output surge, then recovery once it clears
      @(posedge clk_i);
      ov_force <= 1'b1;
      wait_state(ST_FAULT);
      check({30'h0, good, drv.hs}, 32'h0);
      @(posedge clk_i);
      ov_force <= 1'b0;
      wait_state(ST_ON);
      // Input sag below the lockout threshold
      @(posedge clk_i);
      vin_mv <= 16'h07d0;
      wait_state(ST_FAULT);
      @(posedge clk_i);
      vin_mv <= 16'h2ee0;
      wait_state(ST_ON);
      $display("fault test done");
      // Pre-bias above the overvoltage limit blocks turn-on
      @(posedge clk_i);
      turn_on <= 1'b0;
      wait_state(ST_OFF);
      @(posedge clk_i);
      bias_mv <= 12'h5dc;
      turn_on <= 1'b1;
      wait_state(ST_FAULT);
      check({31'h0, drv.hs}, 32'h0);
      @(posedge clk_i);
      bias_mv <= 12'h000;
      wait_state(ST_ON);
      $display("pre-bias test done");
      // External clock: low-side hold request falls back to plain shutdown
      @(posedge clk_i);
      ext_sync <= 1'b1;
      wb_xfer(1'b1, A_OVRESP, 32'h1f, rd);
      @(posedge clk_i);
      ov_force <= 1'b1;
      wait_state(ST_FAULT);
      check({30'h0, drv.ext_sel, drv.ls}, 32'h2);
      @(posedge clk_i);
      ov_force <= 1'b0;
      ext_sync <= 1'b0;
      wait_state(ST_ON);
      $display("external clock test done");
      test_done();
   end
endmodule
`default_nettype wire
